// [bench/pcrs_core_model.sv]
// Model of the core decoder that issues counter and stack operations
`timescale 1ns/1ns
module pcrs_core_model (
  // Clock
  input  wire logic           pclk,
  // Operation request
  output pcrs_pkg::pcrs_req_t core_req
);
  initial core_req = '{op: pcrs_pkg::OP_NONE, target: 21'h000000, data: 8'h00};

  // ---------------------------------------------------------------
  // One operation, then idle cycles to model a slow decoder
  // ---------------------------------------------------------------
  task automatic issue(input pcrs_pkg::pcrs_op_t o, input logic [20:0] t, input int idle);
    @(posedge pclk);
    core_req <= '{op: o, target: t, data: 8'h5A};
    @(posedge pclk);
    core_req.op     <= pcrs_pkg::OP_NONE;
    // Stale target must not look valid once released
    core_req.target <= ~t;
    repeat (idle) @(posedge pclk);
    @(negedge pclk);
  endtask
endmodule

// [bench/tb_program_counter_return_stack.sv]
// Self-checking testbench for the program counter and return stack
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_program_counter_return_stack;
  logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0, prdata, d;
  logic                pready, pslverr, last_err, device_reset = 1'b0, dbg = 1'b0, sfr, ovf, unf;
  logic [20:0]         pc;
  pcrs_pkg::pcrs_req_t core_req;
  int                  errors = 0, tests_run = 0;

  always #20 pclk = ~pclk;

  pcrs_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_req(core_req), .device_reset(device_reset), .in_circuit_debug_mode(dbg),
    .program_counter(pc), .stack_fault_reset(sfr), .stack_overflow_flag(ovf),
    .stack_underflow_flag(unf));
  pcrs_core_model core (.pclk(pclk), .core_req(core_req));

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Look mid-cycle: pready and prdata are settled and stand until the next edge
    @(negedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    `CHK(n < 100, 1'b1)
    d        = prdata;
    last_err = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Let the completing edge's updates land before callers look
    @(negedge pclk);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(d, e)
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk_reg(pcrs_pkg::OFF_COUNTER_LOW, 32'h0);
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h0);
    chk_reg(pcrs_pkg::OFF_RESET_CAUSE, 32'h0);
    chk_reg(pcrs_pkg::OFF_CONFIG, 32'h1);
    chk_reg(8'h24, 32'h0);
    `CHK(last_err, 1'b1)
  endtask

  task automatic t_latch();
    apb(1'b1, pcrs_pkg::OFF_HIGH_LATCH, 32'h12);
    apb(1'b1, pcrs_pkg::OFF_UPPER_LATCH, 32'h1A);
    `CHK(pc, 21'h000000)
    apb(1'b1, pcrs_pkg::OFF_COUNTER_LOW, 32'h35);
    `CHK(pc, 21'h1A1234)
    chk_reg(pcrs_pkg::OFF_COUNTER_LOW, 32'h34);
    apb(1'b1, pcrs_pkg::OFF_HIGH_LATCH, 32'h0);
    apb(1'b1, pcrs_pkg::OFF_UPPER_LATCH, 32'h0);
    `CHK(pc, 21'h1A1234)
    apb(1'b0, pcrs_pkg::OFF_COUNTER_LOW, 32'h0);
    chk_reg(pcrs_pkg::OFF_HIGH_LATCH, 32'h12);
    chk_reg(pcrs_pkg::OFF_UPPER_LATCH, 32'h1A);
    core.issue(pcrs_pkg::OP_ADVANCE, 21'h0, 0);
    `CHK(pc, 21'h1A1236)
    core.issue(pcrs_pkg::OP_JUMP, 21'h0ABCDF, 2);
    `CHK(pc, 21'h0ABCDE)
    core.issue(pcrs_pkg::OP_PCL_READ, 21'h0, 0);
    chk_reg(pcrs_pkg::OFF_HIGH_LATCH, 32'hBC);
    core.issue(pcrs_pkg::OP_PCL_WRITE, 21'h0, 0);
    `CHK(pc, 21'h0ABC5A)
    core.issue(pcrs_pkg::OP_JUMP, 21'h0ABCDE, 0);
    apb(1'b1, pcrs_pkg::OFF_HIGH_LATCH, 32'h12);
  endtask

  task automatic t_calls();
    core.issue(pcrs_pkg::OP_CALL, 21'h001001, 0);
    `CHK(pc, 21'h001000)
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h1);
    chk_reg(pcrs_pkg::OFF_TOP_UPPER, 32'h0A);
    chk_reg(pcrs_pkg::OFF_TOP_HIGH, 32'hBC);
    chk_reg(pcrs_pkg::OFF_TOP_LOW, 32'hDE);
    core.issue(pcrs_pkg::OP_RELATIVE_CALL, 21'h002000, 0);
    core.issue(pcrs_pkg::OP_INT_ACK, 21'h000008, 0);
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h3);
    core.issue(pcrs_pkg::OP_RETURN_FROM_INTERRUPT, 21'h0, 0);
    `CHK(pc, 21'h002000)
    core.issue(pcrs_pkg::OP_RETURN_WITH_LITERAL, 21'h0, 0);
    `CHK(pc, 21'h001000)
    chk_reg(pcrs_pkg::OFF_HIGH_LATCH, 32'h12);
    apb(1'b1, pcrs_pkg::OFF_TOP_LOW, 32'h56);
    apb(1'b1, pcrs_pkg::OFF_TOP_HIGH, 32'h34);
    apb(1'b1, pcrs_pkg::OFF_TOP_UPPER, 32'h02);
    core.issue(pcrs_pkg::OP_RETURN, 21'h0, 0);
    `CHK(pc, 21'h023456)
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h0);
  endtask

  task automatic t_underflow();
    core.issue(pcrs_pkg::OP_RETURN, 21'h0, 0);
    `CHK({pc, unf, sfr}, {21'h0, 2'b11})
    chk_reg(pcrs_pkg::OFF_RESET_CAUSE, 32'h40);
    apb(1'b1, pcrs_pkg::OFF_RESET_CAUSE, 32'h0);
    `CHK(unf, 1'b0)
    apb(1'b1, pcrs_pkg::OFF_CONFIG, 32'h0);
    core.issue(pcrs_pkg::OP_JUMP, 21'h000100, 0);
    core.issue(pcrs_pkg::OP_RETURN_WITH_LITERAL, 21'h0, 0);
    `CHK({pc, unf, sfr}, {21'h0, 2'b10})
    chk_reg(pcrs_pkg::OFF_HIGH_LATCH, 32'h12);
  endtask

  task automatic t_overflow();
    apb(1'b1, pcrs_pkg::OFF_RESET_CAUSE, 32'h0);
    for (int i = 1; i <= 31; i++) begin
      core.issue(pcrs_pkg::OP_CALL, 21'(i * 4), 0);
    end
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h1F);
    `CHK(ovf, 1'b0)
    core.issue(pcrs_pkg::OP_PUSH, 21'h0, 0);
    `CHK({pc, ovf, sfr}, {21'h00007C, 2'b10})
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h1F);
    chk_reg(pcrs_pkg::OFF_TOP_LOW, 32'h7C);
    apb(1'b1, pcrs_pkg::OFF_RESET_CAUSE, 32'h80);
    `CHK({ovf, sfr}, 2'b10)
    apb(1'b1, pcrs_pkg::OFF_RESET_CAUSE, 32'h0);
    apb(1'b1, pcrs_pkg::OFF_CONFIG, 32'h1);
    core.issue(pcrs_pkg::OP_CALL_VIA_W, 21'h000400, 0);
    `CHK({ovf, sfr}, 2'b11)
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h0);
  endtask

  task automatic t_pushpop();
    core.issue(pcrs_pkg::OP_PUSH, 21'h0, 0);
    chk_reg(pcrs_pkg::OFF_TOP_HIGH, 32'h04);
    core.issue(pcrs_pkg::OP_POP, 21'h0, 0);
    `CHK(pc, 21'h000400)
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h0);
  endtask

  task automatic t_depth_and_reset();
    @(posedge pclk);
    dbg <= 1'b1;
    apb(1'b1, pcrs_pkg::OFF_STACK_POINTER, 32'h23);
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h23);
    @(posedge pclk);
    dbg <= 1'b0;
    // Only five pointer bits are writable outside debug
    apb(1'b1, pcrs_pkg::OFF_STACK_POINTER, 32'h23);
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h03);
    // Core traffic during an access must stall the bus, not lose either side
    fork
      apb(1'b0, pcrs_pkg::OFF_STACK_POINTER, 32'h0);
      core.issue(pcrs_pkg::OP_ADVANCE, 21'h0, 0);
    join
    `CHK({d, pc}, {32'h03, 21'h000402})
    @(posedge pclk);
    device_reset <= 1'b1;
    @(posedge pclk);
    device_reset <= 1'b0;
    @(negedge pclk);
    `CHK({pc, ovf}, {21'h0, 1'b1})
    chk_reg(pcrs_pkg::OFF_STACK_POINTER, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_latch();
    t_calls();
    t_underflow();
    t_overflow();
    t_pushpop();
    t_depth_and_reset();
    close_out();
  end

  initial begin
    #(40 * 20000);
    errors++;
    close_out();
  end
endmodule

// [hw/pcrs_core.sv]
// Program counter with latches and hardware return-address stack, APB register access
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module pcrs_core (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Core decoder side
  input  wire pcrs_pkg::pcrs_req_t   core_req,
  input  wire logic                  device_reset,
  input  wire logic                  in_circuit_debug_mode,
  output logic      [20:0]           program_counter,
  output logic                       stack_fault_reset,
  output logic                       stack_overflow_flag,
  output logic                       stack_underflow_flag
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pcrs_pkg::pcrs_state_t st_reg;
  pcrs_pkg::pcrs_state_t st_next;
  logic                  done;
  logic                  core_busy;
  logic [5:0]            max_ptr;
  logic [20:0]           top_value;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  assign core_busy = (core_req.op != pcrs_pkg::OP_NONE);
  // Core operations own the cycle; APB waits so both never touch the same state together
  assign pready    = psel & penable & st_reg.fresh & ~core_busy;
  assign done      = pready;
  assign max_ptr   = in_circuit_debug_mode ? pcrs_pkg::DEPTH_DEBUG : pcrs_pkg::DEPTH_NORMAL;
  // Entry zero is never written, so it reads as zero
  assign top_value = st_reg.stk[st_reg.ptr];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.fault_rst = 1'b0;
    unique case (core_req.op)
      pcrs_pkg::OP_NONE: begin
      end
      pcrs_pkg::OP_ADVANCE: begin
        st_next.pc = st_reg.pc + pcrs_pkg::PC_STEP;
      end
      pcrs_pkg::OP_JUMP: begin
        st_next.pc = {core_req.target[20:1], 1'b0};
      end
      pcrs_pkg::OP_CALL, pcrs_pkg::OP_RELATIVE_CALL, pcrs_pkg::OP_CALL_VIA_W,
      pcrs_pkg::OP_INT_ACK, pcrs_pkg::OP_PUSH: begin
        // Latches untouched on every push path
        if (st_reg.ptr >= max_ptr) begin
          st_next.ovf = 1'b1;
          if (st_reg.fault_en) begin
            st_next.fault_rst = 1'b1;
            st_next.ptr       = pcrs_pkg::RST_PTR;
          end else begin
            st_next.stk[max_ptr] = st_reg.pc;
            st_next.ptr          = max_ptr;
          end
        end else begin
          st_next.ptr                        = st_reg.ptr + 6'h01;
          st_next.stk[st_reg.ptr + 6'h01]    = st_reg.pc;
        end
        if (core_req.op != pcrs_pkg::OP_PUSH) begin
          st_next.pc = {core_req.target[20:1], 1'b0};
        end
      end
      pcrs_pkg::OP_RETURN, pcrs_pkg::OP_RETURN_WITH_LITERAL,
      pcrs_pkg::OP_RETURN_FROM_INTERRUPT: begin
        if (st_reg.ptr == pcrs_pkg::RST_PTR) begin
          st_next.pc        = pcrs_pkg::RST_PC;
          st_next.unf       = 1'b1;
          st_next.fault_rst = st_reg.fault_en;
        end else begin
          st_next.pc  = {top_value[20:1], 1'b0};
          st_next.ptr = st_reg.ptr - 6'h01;
        end
      end
      pcrs_pkg::OP_POP: begin
        // Discard only; the counter keeps running from where it was
        if (st_reg.ptr == pcrs_pkg::RST_PTR) begin
          st_next.unf       = 1'b1;
          st_next.fault_rst = st_reg.fault_en;
        end else begin
          st_next.ptr = st_reg.ptr - 6'h01;
        end
      end
      pcrs_pkg::OP_PCL_WRITE: begin
        st_next.pc = {st_reg.upper_latch, st_reg.high_latch, core_req.data[7:1], 1'b0};
      end
      pcrs_pkg::OP_PCL_READ: begin
        st_next.high_latch  = st_reg.pc[15:8];
        st_next.upper_latch = st_reg.pc[20:16];
      end
    endcase

    // ---------------------------------------------------------------
    // APB completion
    // ---------------------------------------------------------------
    if (done && pwrite) begin
      if (hit(paddr, pcrs_pkg::OFF_COUNTER_LOW)) begin
        st_next.pc = {st_reg.upper_latch, st_reg.high_latch, pwdata[7:1], 1'b0};
      end
      if (hit(paddr, pcrs_pkg::OFF_HIGH_LATCH)) begin
        st_next.high_latch = pwdata[7:0];
      end
      if (hit(paddr, pcrs_pkg::OFF_UPPER_LATCH)) begin
        st_next.upper_latch = pwdata[4:0];
      end
      // Writes at pointer zero fall on nothing
      if (st_reg.ptr != pcrs_pkg::RST_PTR) begin
        if (hit(paddr, pcrs_pkg::OFF_TOP_LOW)) begin
          st_next.stk[st_reg.ptr][7:0] = pwdata[7:0];
        end
        if (hit(paddr, pcrs_pkg::OFF_TOP_HIGH)) begin
          st_next.stk[st_reg.ptr][15:8] = pwdata[7:0];
        end
        if (hit(paddr, pcrs_pkg::OFF_TOP_UPPER)) begin
          st_next.stk[st_reg.ptr][20:16] = pwdata[4:0];
        end
      end
      if (hit(paddr, pcrs_pkg::OFF_STACK_POINTER)) begin
        st_next.ptr = in_circuit_debug_mode ? pwdata[5:0] : {1'b0, pwdata[4:0]};
        if (st_next.ptr > max_ptr) begin
          st_next.ptr = max_ptr;
        end
      end
      if (hit(paddr, pcrs_pkg::OFF_RESET_CAUSE)) begin
        // Plain store, never a reset
        st_next.ovf = pwdata[pcrs_pkg::BIT_OVERFLOW];
        st_next.unf = pwdata[pcrs_pkg::BIT_UNDERFLOW];
      end
      if (hit(paddr, pcrs_pkg::OFF_CONFIG)) begin
        st_next.fault_en = pwdata[pcrs_pkg::BIT_FAULT_RST];
      end
    end
    if (done && !pwrite && hit(paddr, pcrs_pkg::OFF_COUNTER_LOW)) begin
      st_next.high_latch  = st_reg.pc[15:8];
      st_next.upper_latch = st_reg.pc[20:16];
    end

    // ---------------------------------------------------------------
    // Read data, captured while the transfer waits
    // ---------------------------------------------------------------
    if (psel) begin
      st_next.prdata = 32'h00000000;
      st_next.slverr = 1'b0;
      if (hit(paddr, pcrs_pkg::OFF_COUNTER_LOW)) begin
        st_next.prdata[7:0] = st_reg.pc[7:0];
      end else if (hit(paddr, pcrs_pkg::OFF_HIGH_LATCH)) begin
        st_next.prdata[7:0] = st_reg.high_latch;
      end else if (hit(paddr, pcrs_pkg::OFF_UPPER_LATCH)) begin
        st_next.prdata[4:0] = st_reg.upper_latch;
      end else if (hit(paddr, pcrs_pkg::OFF_TOP_LOW)) begin
        st_next.prdata[7:0] = top_value[7:0];
      end else if (hit(paddr, pcrs_pkg::OFF_TOP_HIGH)) begin
        st_next.prdata[7:0] = top_value[15:8];
      end else if (hit(paddr, pcrs_pkg::OFF_TOP_UPPER)) begin
        st_next.prdata[4:0] = top_value[20:16];
      end else if (hit(paddr, pcrs_pkg::OFF_STACK_POINTER)) begin
        st_next.prdata[5:0] = in_circuit_debug_mode ? st_reg.ptr : {1'b0, st_reg.ptr[4:0]};
      end else if (hit(paddr, pcrs_pkg::OFF_RESET_CAUSE)) begin
        st_next.prdata[pcrs_pkg::BIT_OVERFLOW]  = st_reg.ovf;
        st_next.prdata[pcrs_pkg::BIT_UNDERFLOW] = st_reg.unf;
      end else if (hit(paddr, pcrs_pkg::OFF_CONFIG)) begin
        st_next.prdata[pcrs_pkg::BIT_FAULT_RST] = st_reg.fault_en;
      end else begin
        st_next.slverr = 1'b1;
      end
    end
    // Captured data is only trusted after a cycle with no core operation and no completed transfer
    st_next.fresh = psel & ~core_busy & ~done;

    // Device reset: flags survive; power-on reset or a reset cause register write clears them
    if (device_reset) begin
      st_next.pc  = pcrs_pkg::RST_PC;
      st_next.ptr = pcrs_pkg::RST_PTR;
    end
    st_next.pc[0] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg             <= '0;
      st_reg.pc          <= pcrs_pkg::RST_PC;
      st_reg.high_latch  <= pcrs_pkg::RST_HIGH_LATCH;
      st_reg.upper_latch <= pcrs_pkg::RST_UPPER_LATCH;
      st_reg.ptr         <= pcrs_pkg::RST_PTR;
      st_reg.fault_en    <= pcrs_pkg::RST_FAULT_EN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata               = st_reg.prdata;
  assign pslverr              = st_reg.slverr & pready;
  assign program_counter      = st_reg.pc;
  assign stack_fault_reset    = st_reg.fault_rst;
  assign stack_overflow_flag  = st_reg.ovf;
  assign stack_underflow_flag = st_reg.unf;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic is_push;
  logic is_ret;
  assign is_push = core_req.op inside {pcrs_pkg::OP_CALL, pcrs_pkg::OP_RELATIVE_CALL,
                                       pcrs_pkg::OP_CALL_VIA_W, pcrs_pkg::OP_INT_ACK, pcrs_pkg::OP_PUSH};
  assign is_ret  = core_req.op inside {pcrs_pkg::OP_RETURN, pcrs_pkg::OP_RETURN_WITH_LITERAL,
                                       pcrs_pkg::OP_RETURN_FROM_INTERRUPT};

  a_pc_lsb_zero: assert property (program_counter[0] == 1'b0)
    else $error("Counter bit 0 is set");
  a_advance_two: assert property (core_req.op == pcrs_pkg::OP_ADVANCE && !device_reset
    |=> program_counter == $past(program_counter) + pcrs_pkg::PC_STEP)
    else $error("Advance did not add two");
  a_push_ptr_store: assert property (is_push && !device_reset && st_reg.ptr < max_ptr
    |=> st_reg.ptr == $past(st_reg.ptr) + 6'h01 && top_value == $past(program_counter))
    else $error("Push did not raise pointer and store counter");
  a_pop_load: assert property (is_ret && !device_reset && st_reg.ptr != 6'h00
    |=> program_counter == {$past(top_value[20:1]), 1'b0} && st_reg.ptr == $past(st_reg.ptr) - 6'h01)
    else $error("Return did not load entry and lower pointer");
  a_ovf_with_reset: assert property (is_push && !device_reset && st_reg.ptr == max_ptr && st_reg.fault_en
    |=> stack_fault_reset && stack_overflow_flag && st_reg.ptr == 6'h00 ##1 !stack_fault_reset)
    else $error("Overflow with reset enable misbehaved");
  a_ovf_no_reset: assert property (is_push && !device_reset && st_reg.ptr == max_ptr && !st_reg.fault_en
    |=> !stack_fault_reset && stack_overflow_flag && st_reg.ptr == $past(max_ptr))
    else $error("Overflow without reset enable misbehaved");
  a_unf_return: assert property (is_ret && !device_reset && st_reg.ptr == 6'h00
    |=> program_counter == 21'h000000 && stack_underflow_flag
        && stack_fault_reset == $past(st_reg.fault_en))
    else $error("Empty return misbehaved");
  a_pcl_write_latch: assert property (core_req.op == pcrs_pkg::OP_PCL_WRITE && !device_reset
    |=> program_counter[20:8] == {$past(st_reg.upper_latch), $past(st_reg.high_latch)})
    else $error("Low byte write did not transfer latches");
  a_pcl_read_latch: assert property (core_req.op == pcrs_pkg::OP_PCL_READ
    |=> st_reg.high_latch == $past(program_counter[15:8])
        && st_reg.upper_latch == $past(program_counter[20:16]))
    else $error("Low byte read did not fill latches");
  a_latch_hold_calls: assert property ((is_push || is_ret || core_req.op == pcrs_pkg::OP_JUMP)
    |=> $stable(st_reg.high_latch) && $stable(st_reg.upper_latch))
    else $error("Latch changed on call or return");
  a_flag_sticky: assert property (stack_overflow_flag && !(done && pwrite && hit(paddr, pcrs_pkg::OFF_RESET_CAUSE))
    |=> stack_overflow_flag)
    else $error("Overflow flag cleared without software");
  a_reset_ptr: assert property (device_reset |=> st_reg.ptr == 6'h00 && program_counter == 21'h000000)
    else $error("Device reset did not clear pointer");

  c_deep_push:  cover property (is_push && st_reg.ptr == max_ptr);
  c_empty_ret:  cover property (is_ret && st_reg.ptr == 6'h00);
  c_pcl_write:  cover property (done && pwrite && hit(paddr, pcrs_pkg::OFF_COUNTER_LOW));
  c_top_read:   cover property (done && !pwrite && hit(paddr, pcrs_pkg::OFF_TOP_LOW) && st_reg.ptr != 6'h00);

endmodule

// [hw/pcrs_pkg.sv]
// Package: constants, types and state of the program counter and return stack block
package pcrs_pkg;

  // ---------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------
  localparam int unsigned PC_W     = 21;
  localparam int unsigned PTR_W    = 6;
  localparam int unsigned ENTRIES  = 36;
  localparam int unsigned PADDR_W  = 8;
  localparam logic [5:0]  DEPTH_NORMAL = 6'h1F;
  localparam logic [5:0]  DEPTH_DEBUG  = 6'h23;
  localparam logic [20:0] PC_STEP      = 21'h000002;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_COUNTER_LOW   = 8'h00;
  localparam logic [7:0] OFF_HIGH_LATCH    = 8'h04;
  localparam logic [7:0] OFF_UPPER_LATCH   = 8'h08;
  localparam logic [7:0] OFF_TOP_LOW       = 8'h0C;
  localparam logic [7:0] OFF_TOP_HIGH      = 8'h10;
  localparam logic [7:0] OFF_TOP_UPPER     = 8'h14;
  localparam logic [7:0] OFF_STACK_POINTER = 8'h18;
  localparam logic [7:0] OFF_RESET_CAUSE   = 8'h1C;
  localparam logic [7:0] OFF_CONFIG        = 8'h20;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned BIT_OVERFLOW   = 7;
  localparam int unsigned BIT_UNDERFLOW  = 6;
  localparam int unsigned BIT_FAULT_RST  = 0;
  localparam logic [20:0] RST_PC         = 21'h000000;
  localparam logic [7:0]  RST_HIGH_LATCH = 8'h00;
  localparam logic [4:0]  RST_UPPER_LATCH = 5'h00;
  localparam logic [5:0]  RST_PTR        = 6'h00;
  localparam logic        RST_FAULT_EN   = 1'b1;

  // ---------------------------------------------------------------
  // Core operations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_ADVANCE,
    OP_JUMP,
    OP_CALL,
    OP_RELATIVE_CALL,
    OP_CALL_VIA_W,
    OP_INT_ACK,
    OP_RETURN,
    OP_RETURN_WITH_LITERAL,
    OP_RETURN_FROM_INTERRUPT,
    OP_PUSH,
    OP_POP,
    OP_PCL_WRITE,
    OP_PCL_READ
  } pcrs_op_t;

  typedef struct packed {
    pcrs_op_t    op;
    logic [20:0] target;
    logic [7:0]  data;
  } pcrs_req_t;

  typedef struct packed {
    logic [35:0][20:0] stk;
    logic [20:0]       pc;
    logic [7:0]        high_latch;
    logic [4:0]        upper_latch;
    logic [5:0]        ptr;
    logic              ovf;
    logic              unf;
    logic              fault_en;
    logic              fault_rst;
    logic [31:0]       prdata;
    logic              slverr;
    logic              fresh;
  } pcrs_state_t;

endpackage
